// *** rtl/tdf_params.svh ***
// timing constants and field widths for the time delay function sequencer
// ==========================================================================
// Notes on behaviour
// - on-delay: time the delay from power up, then energize relay.
// - relay drops to shelf state at once when power goes away.
// - repeat open: off one delay, on one delay, alternating while powered.
// - interval: energize at power up, drop after one delay.
// - repeat closed: on one delay, off one delay, alternating while powered.
// - power-started functions ignore the trigger input completely.
// - off-delay: trigger closing energizes relay at once, no timing.
// - off-delay: trigger opening starts delay; relay drops when it ends.
// - off-delay: reclosing before timeout clears time, relay stays energized.
// - trigger functions act only while powered, idle and off otherwise.
// - one-shot: trigger closure energizes relay and starts delay.
// - one-shot: each new closure before timeout restarts full delay.
`ifndef TDF_PARAMS_SVH
`define TDF_PARAMS_SVH
`define TDF_DLY_W 32
`define TDF_FN_W 3
`define TDF_CLK_NS 10
`define TDF_TICK_NS 1000
`define TDF_TICK_CYC (`TDF_TICK_NS / `TDF_CLK_NS)
`define TDF_DEB_NS 100
`define TDF_DEB_TICKS 8'h05
`define TDF_DEB_W 8
`define TDF_DIV_W 16
`endif

// *** rtl/tdf_pkg.sv ***
// types shared by the sequencer files
package tdf_pkg;
  typedef enum logic [2:0] {
    TDF_FN_ON_DELAY = 3'h0,
    TDF_FN_REP_OPEN = 3'h1,
    TDF_FN_INTERVAL = 3'h2,
    TDF_FN_OFF_DELAY = 3'h3,
    TDF_FN_ONE_SHOT = 3'h4,
    TDF_FN_REP_CLOSED = 3'h5
  } tdf_fn_t;
  typedef enum logic [1:0] {
    TDF_ST_IDLE = 2'h0,
    TDF_ST_TIMING = 2'h1,
    TDF_ST_HOLD = 2'h2,
    TDF_ST_DONE = 2'h3
  } tdf_state_t;
endpackage

// *** rtl/tdf_trig_if.sv ***
// trigger edge carrier between the debouncer and the sequencer
`timescale 1ns/1ps
interface tdf_trig_if;
  logic level;
  logic rise;
  logic fall;
  modport src (output level, output rise, output fall);
  modport dst (input level, input rise, input fall);
endinterface

// *** rtl/tdf_debounce.sv ***
// trigger synchroniser and debouncer with edge pulses
`timescale 1ns/1ps
`include "tdf_params.svh"
module tdf_debounce (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic tick,
  input wire logic trig_raw,
  tdf_trig_if.src trig
);
  logic sync1_ff;
  logic sync2_ff;
  logic stable_ff;
  logic [`TDF_DEB_W-1:0] cnt_ff;

  // ==========================================================================
  // synchroniser: first stage feeds only the second
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      sync1_ff <= 1'b0;
      sync2_ff <= 1'b0;
    end else begin
      sync1_ff <= trig_raw;
      sync2_ff <= sync1_ff;
    end
  end

  // ==========================================================================
  // accept a new level only after it holds for several ticks
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      stable_ff <= 1'b0;
      cnt_ff <= '0;
      trig.rise <= 1'b0;
      trig.fall <= 1'b0;
    end else begin
      trig.rise <= 1'b0;
      trig.fall <= 1'b0;
      if (sync2_ff == stable_ff) begin
        cnt_ff <= '0;
      end else if (tick) begin
        if (cnt_ff == `TDF_DEB_TICKS - 8'h01) begin
          cnt_ff <= '0;
          stable_ff <= sync2_ff;
          trig.rise <= sync2_ff;
          trig.fall <= ~sync2_ff;
        end else begin
          cnt_ff <= cnt_ff + 8'h01;
        end
      end
    end
  end
  assign trig.level = stable_ff;

  a_edge_needs_change: assert property (@(posedge sys_clk) disable iff (!reset_n)
    trig.rise |-> $past(sync2_ff) && !$past(stable_ff))
    else $error("trigger rise without stable change");
endmodule

// *** rtl/tdf_sequencer.sv ***
// time delay relay sequencer top
`timescale 1ns/1ps
`include "tdf_params.svh"
module tdf_sequencer (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic power_in,
  input wire logic trigger_in,
  input wire logic [`TDF_FN_W-1:0] func_sel,
  input wire logic [`TDF_DLY_W-1:0] delay_ticks,
  output logic relay_out,
  output logic timing_out
);
  tdf_trig_if trig ();
  logic [`TDF_DIV_W-1:0] div_ff;
  logic tick_ff;
  logic pwr_ff;
  logic relay_ff;
  logic nxt_relay;
  logic [`TDF_DLY_W-1:0] cnt_ff;
  logic [`TDF_DLY_W-1:0] nxt_cnt;
  tdf_pkg::tdf_state_t st_ff;
  tdf_pkg::tdf_state_t nxt_st;
  tdf_pkg::tdf_fn_t fn_ff;
  logic expire;

  // ==========================================================================
  // tick divider: one-cycle enable per tick period
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      div_ff <= '0;
      tick_ff <= 1'b0;
    end else if (div_ff == 16'(`TDF_TICK_CYC - 1)) begin
      div_ff <= '0;
      tick_ff <= 1'b1;
    end else begin
      div_ff <= div_ff + 16'h0001;
      tick_ff <= 1'b0;
    end
  end

  tdf_debounce u_deb (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .tick(tick_ff),
    .trig_raw(trigger_in),
    .trig(trig)
  );

  // ==========================================================================
  // power edge and function latch; function frozen while powered
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      pwr_ff <= 1'b0;
      fn_ff <= tdf_pkg::TDF_FN_ON_DELAY;
    end else begin
      pwr_ff <= power_in;
      if (!power_in) begin
        fn_ff <= tdf_pkg::tdf_fn_t'(func_sel);
      end
    end
  end

  // a zero delay expires at the first tick
  assign expire = tick_ff && (cnt_ff <= 32'h00000001);

  // ==========================================================================
  // sequencer
  always_comb begin
    nxt_st = st_ff;
    nxt_relay = relay_ff;
    nxt_cnt = cnt_ff;
    if (st_ff == tdf_pkg::TDF_ST_TIMING && tick_ff && cnt_ff != '0) begin
      nxt_cnt = cnt_ff - 32'h00000001;
    end
    if (!power_in) begin
      nxt_st = tdf_pkg::TDF_ST_IDLE;
      nxt_relay = 1'b0;
      nxt_cnt = '0;
    end else if (!pwr_ff) begin
      // power just applied; trigger functions wait idle
      nxt_cnt = delay_ticks;
      case (fn_ff)
        tdf_pkg::TDF_FN_ON_DELAY, tdf_pkg::TDF_FN_REP_OPEN: begin
          nxt_st = tdf_pkg::TDF_ST_TIMING;
          nxt_relay = 1'b0;
        end
        tdf_pkg::TDF_FN_INTERVAL, tdf_pkg::TDF_FN_REP_CLOSED: begin
          nxt_st = tdf_pkg::TDF_ST_TIMING;
          nxt_relay = 1'b1;
        end
        default: begin
          nxt_st = tdf_pkg::TDF_ST_IDLE;
          nxt_relay = 1'b0;
        end
      endcase
    end else begin
      // power functions never look at trig
      case (fn_ff)
        tdf_pkg::TDF_FN_ON_DELAY: begin
          if (st_ff == tdf_pkg::TDF_ST_TIMING && expire) begin
            nxt_st = tdf_pkg::TDF_ST_DONE;
            nxt_relay = 1'b1;
          end
        end
        tdf_pkg::TDF_FN_INTERVAL: begin
          if (st_ff == tdf_pkg::TDF_ST_TIMING && expire) begin
            nxt_st = tdf_pkg::TDF_ST_DONE;
            nxt_relay = 1'b0;
          end
        end
        tdf_pkg::TDF_FN_REP_OPEN, tdf_pkg::TDF_FN_REP_CLOSED: begin
          if (st_ff == tdf_pkg::TDF_ST_TIMING && expire) begin
            nxt_relay = ~relay_ff;
            nxt_cnt = delay_ticks;
          end
        end
        tdf_pkg::TDF_FN_OFF_DELAY: begin
          if (trig.level) begin
            nxt_st = tdf_pkg::TDF_ST_HOLD;
            nxt_relay = 1'b1;
            nxt_cnt = delay_ticks;
          end else if (trig.fall && relay_ff) begin
            nxt_st = tdf_pkg::TDF_ST_TIMING;
            nxt_cnt = delay_ticks;
          end else if (st_ff == tdf_pkg::TDF_ST_TIMING && expire) begin
            nxt_st = tdf_pkg::TDF_ST_IDLE;
            nxt_relay = 1'b0;
          end
        end
        tdf_pkg::TDF_FN_ONE_SHOT: begin
          if (trig.rise) begin
            nxt_st = tdf_pkg::TDF_ST_TIMING;
            nxt_relay = 1'b1;
            nxt_cnt = delay_ticks;
          end else if (st_ff == tdf_pkg::TDF_ST_TIMING && expire) begin
            nxt_st = tdf_pkg::TDF_ST_IDLE;
            nxt_relay = 1'b0;
          end
        end
        default: begin
          nxt_st = tdf_pkg::TDF_ST_IDLE;
          nxt_relay = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      st_ff <= tdf_pkg::TDF_ST_IDLE;
      relay_ff <= 1'b0;
      cnt_ff <= '0;
      timing_out <= 1'b0;
    end else begin
      st_ff <= nxt_st;
      relay_ff <= nxt_relay;
      cnt_ff <= nxt_cnt;
      timing_out <= (nxt_st == tdf_pkg::TDF_ST_TIMING);
    end
  end
  assign relay_out = relay_ff;

  // ==========================================================================
  // checks
  a_power_loss_drop: assert property (@(posedge sys_clk) disable iff (!reset_n)
    !power_in |=> !relay_out)
    else $error("relay on one cycle after power loss");
  a_interval_start_on: assert property (@(posedge sys_clk) disable iff (!reset_n)
    power_in && !pwr_ff && fn_ff == tdf_pkg::TDF_FN_INTERVAL |=> relay_out)
    else $error("interval did not energize at power up");
  a_ondelay_start_off: assert property (@(posedge sys_clk) disable iff (!reset_n)
    power_in && !pwr_ff && fn_ff == tdf_pkg::TDF_FN_ON_DELAY |=> !relay_out)
    else $error("on-delay energized early");
  a_repclosed_start_on: assert property (@(posedge sys_clk) disable iff (!reset_n)
    power_in && !pwr_ff && fn_ff == tdf_pkg::TDF_FN_REP_CLOSED |=> relay_out)
    else $error("repeat closed did not start on");
  a_repopen_start_off: assert property (@(posedge sys_clk) disable iff (!reset_n)
    power_in && !pwr_ff && fn_ff == tdf_pkg::TDF_FN_REP_OPEN |=> !relay_out)
    else $error("repeat open did not start off");
  a_offdelay_close_on: assert property (@(posedge sys_clk) disable iff (!reset_n)
    power_in && pwr_ff && fn_ff == tdf_pkg::TDF_FN_OFF_DELAY && trig.level |=> relay_out)
    else $error("off-delay not energized while trigger closed");
  a_oneshot_fire: assert property (@(posedge sys_clk) disable iff (!reset_n)
    power_in && pwr_ff && fn_ff == tdf_pkg::TDF_FN_ONE_SHOT && trig.rise
    |=> relay_out && cnt_ff == $past(delay_ticks))
    else $error("one-shot did not reload on trigger");
  a_trig_idle_off: assert property (@(posedge sys_clk) disable iff (!reset_n)
    power_in && !pwr_ff && fn_ff == tdf_pkg::TDF_FN_ONE_SHOT |=> !relay_out)
    else $error("trigger function energized at power up");
  a_tick_period: assert property (@(posedge sys_clk) disable iff (!reset_n)
    tick_ff |=> !tick_ff [*8])
    else $error("tick enable too frequent");
endmodule

// *** sim/tdf_switch_model.sv ***
// trigger switch model with contact bounce
`timescale 1ns/1ps
// ==========================================================================
// switch model
module tdf_switch_model (
  input wire logic sys_clk,
  output logic contact
);
  initial contact = 1'b0;
  // a dry contact never lands cleanly, so every move chatters first
  task automatic set_contact(input logic closed);
    int i;
    for (i = 0; i < 6; i++) begin
      repeat (20) @(negedge sys_clk);
      contact = (i % 2 == 0) ? closed : ~closed;
    end
    repeat (20) @(negedge sys_clk);
    contact = closed;
  endtask
endmodule

// *** sim/tdf_sequencer_test.sv ***
// self-checking bench for the relay sequencer
`timescale 1ns/1ps
`include "tdf_params.svh"
// ==========================================================================
// bench
module tdf_sequencer_test;
  typedef struct {logic v; time lo; time hi; time ref_t; bit rel;} tdf_note_t;
  localparam time TK = 1000;
  logic sys_clk;
  logic reset_n;
  logic power_in;
  logic trigger_in;
  logic [`TDF_FN_W-1:0] func_sel;
  logic [`TDF_DLY_W-1:0] delay_ticks;
  logic relay_out;
  logic timing_out;
  int n_mismatch = 0;
  int samples_checked = 0;
  tdf_note_t notes[$];
  tdf_note_t cur;
  time last_edge = 0;
  logic last_relay = 1'b0;
  bit mon_on = 1'b0;
  int d;
  int k;

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  tdf_sequencer uut (.sys_clk(sys_clk), .reset_n(reset_n), .power_in(power_in),
    .trigger_in(trigger_in), .func_sel(func_sel), .delay_ticks(delay_ticks),
    .relay_out(relay_out), .timing_out(timing_out));
  tdf_switch_model sw (.sys_clk(sys_clk), .contact(trigger_in));

  task automatic finish_test();
    if (n_mismatch == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic fail(input string msg);
    n_mismatch++;
    $display("CHECK FAILED %0t %s", $time, msg);
  endtask

  task automatic compare_edge(input logic got, input tdf_note_t n, input time gap);
    samples_checked++;
    if (got !== n.v || gap < n.lo || gap > n.hi) fail($sformatf("relay %b after %0t", got, gap));
  endtask

  // timing_out is a level, so it is looked at directly while it stands
  task automatic compare_timing(input logic exp);
    samples_checked++;
    if (timing_out !== exp) fail($sformatf("timing %b, wanted %b", timing_out, exp));
  endtask

  // rel: measured from the previous relay change, else from now
  task automatic expect_edge(input logic v, input time lo, input time hi, input bit rel);
    tdf_note_t n;
    n.v = v;
    n.lo = lo;
    n.hi = hi;
    n.ref_t = $time;
    n.rel = rel;
    notes.push_back(n);
  endtask

  task automatic wait_drain(input int bound);
    int i;
    for (i = 0; i < bound && notes.size() > 0; i++) @(negedge sys_clk);
    if (notes.size() > 0) begin
      fail("expected relay change missing");
      finish_test();
    end
  endtask

  task automatic power_up(input logic [`TDF_FN_W-1:0] fn, input int dly);
    @(negedge sys_clk);
    func_sel = fn;
    delay_ticks = 32'(dly);
    @(negedge sys_clk);
    power_in = 1'b1;
  endtask

  task automatic power_down(input bit was_on);
    @(negedge sys_clk);
    power_in = 1'b0;
    if (was_on) expect_edge(1'b0, 0, 30, 1'b0);
    wait_drain(10);
    repeat (20) @(negedge sys_clk);
  endtask

  // any relay change without a pending note is a mismatch
  always @(negedge sys_clk) begin
    if (mon_on && relay_out !== last_relay) begin
      if (notes.size() == 0) fail("unexpected relay change");
      else begin
        cur = notes.pop_front();
        compare_edge(relay_out, cur, $time - (cur.rel ? last_edge : cur.ref_t));
      end
      last_relay = relay_out;
      last_edge = $time;
    end
  end

  initial begin
    repeat (100000) @(negedge sys_clk);
    fail("run too long");
    finish_test();
  end

  initial begin
    reset_n = 1'b0;
    power_in = 1'b0;
    func_sel = 3'h0;
    delay_ticks = 32'h00000004;
    void'($urandom(32'hEECA9B37));
    repeat (6) @(negedge sys_clk);
    reset_n = 1'b1;
    mon_on = 1'b1;
    d = 3 + $urandom % 4;
    power_up(tdf_pkg::TDF_FN_ON_DELAY, d);
    expect_edge(1'b1, (d - 1) * TK, (d + 1) * TK + 50, 1'b0);
    @(negedge sys_clk);
    compare_timing(1'b1);
    sw.set_contact(1'b1);
    repeat (700) @(negedge sys_clk);
    sw.set_contact(1'b0);
    wait_drain((d + 3) * 100);
    compare_timing(1'b0);
    power_down(1'b1);
    power_up(tdf_pkg::TDF_FN_REP_OPEN, d);
    expect_edge(1'b1, (d - 1) * TK, (d + 1) * TK + 50, 1'b0);
    expect_edge(1'b0, (d - 1) * TK, (d + 1) * TK + 50, 1'b1);
    expect_edge(1'b1, (d - 1) * TK, (d + 1) * TK + 50, 1'b1);
    wait_drain((3 * d + 4) * 100);
    power_down(1'b1);
    power_up(tdf_pkg::TDF_FN_INTERVAL, d);
    expect_edge(1'b1, 0, 50, 1'b0);
    expect_edge(1'b0, (d - 1) * TK, (d + 1) * TK + 50, 1'b1);
    wait_drain((d + 3) * 100);
    power_down(1'b0);
    power_up(tdf_pkg::TDF_FN_REP_CLOSED, d);
    expect_edge(1'b1, 0, 50, 1'b0);
    expect_edge(1'b0, (d - 1) * TK, (d + 1) * TK + 50, 1'b1);
    expect_edge(1'b1, (d - 1) * TK, (d + 1) * TK + 50, 1'b1);
    wait_drain((2 * d + 4) * 100);
    power_down(1'b1);
    func_sel = tdf_pkg::TDF_FN_OFF_DELAY;
    sw.set_contact(1'b1);
    repeat (800) @(negedge sys_clk);
    sw.set_contact(1'b0);
    repeat (800) @(negedge sys_clk);
    power_up(tdf_pkg::TDF_FN_OFF_DELAY, 12);
    sw.set_contact(1'b1);
    expect_edge(1'b1, 4 * TK, 7 * TK + 50, 1'b0);
    wait_drain(800);
    compare_timing(1'b0);
    sw.set_contact(1'b0);
    repeat (800) @(negedge sys_clk);
    sw.set_contact(1'b1);
    repeat (1000) @(negedge sys_clk);
    sw.set_contact(1'b0);
    expect_edge(1'b0, 15 * TK, 20 * TK + 50, 1'b0);
    repeat (700) @(negedge sys_clk);
    compare_timing(1'b1);
    wait_drain(2100);
    compare_timing(1'b0);
    power_down(1'b0);
    power_up(tdf_pkg::TDF_FN_ONE_SHOT, 20);
    sw.set_contact(1'b1);
    expect_edge(1'b1, 4 * TK, 7 * TK + 50, 1'b0);
    for (k = 0; k < 3; k++) begin
      repeat (600) @(negedge sys_clk);
      sw.set_contact(1'b0);
      repeat (600) @(negedge sys_clk);
      sw.set_contact(1'b1);
    end
    expect_edge(1'b0, 23 * TK, 28 * TK + 50, 1'b0);
    wait_drain(3000);
    power_down(1'b0);
    // unused select codes must leave the relay off and nothing timing
    power_up(3'h6, 3);
    repeat (500) @(negedge sys_clk);
    compare_timing(1'b0);
    power_down(1'b0);
    finish_test();
  end
endmodule
